// ---- pkg/pwm_pkg.sv ----
// Package for the standard PWM unit: register offsets, field layout, reset values, modes.
// Assumes a plain address/strobe register port with 8-bit data, read data one cycle later.
package pwm_pkg;
	// Register offsets
	localparam logic [3:0] OFS_UNIT_CONTROL  = 4'h0;
	localparam logic [3:0] OFS_CC_LOW_BYTE   = 4'h1;
	localparam logic [3:0] OFS_CC_HIGH_BYTE  = 4'h2;
	localparam logic [3:0] OFS_PERIOD_REG    = 4'h3;
	localparam logic [3:0] OFS_TIMER_CONTROL = 4'h4;
	localparam logic [3:0] OFS_TIMER_COUNT   = 4'h5;
	localparam logic [3:0] OFS_TIMER_STATUS  = 4'h6;
	localparam logic [3:0] OFS_TIMER_SELECT  = 4'h7;
	localparam logic [3:0] OFS_ALT_PIN       = 4'h8;
	localparam logic [3:0] OFS_PIN_DIRECTION = 4'h9;
	// Unit control field positions
	localparam int CFG_MSB  = 7;
	localparam int CFG_LSB  = 6;
	localparam int DUTY_MSB = 5;
	localparam int DUTY_LSB = 4;
	localparam int MODE_MSB = 3;
	localparam int MODE_LSB = 0;
	// Timer control field positions
	localparam int RUN_BIT  = 2;
	localparam int PRE_MSB  = 1;
	localparam int PRE_LSB  = 0;
	// Mode select codes: PWM when the upper two mode bits are set
	localparam logic [1:0] MODE_PWM_TOP = 2'h3;
	// Prescale codes
	localparam logic [1:0] PRESCALE_1  = 2'h0;
	localparam logic [1:0] PRESCALE_4  = 2'h1;
	localparam logic [1:0] PRESCALE_16 = 2'h2;
	// Reset values
	localparam logic [7:0] RST_ZERO      = 8'h00;
	localparam logic [7:0] RST_PERIOD    = 8'hff;
	localparam logic       RST_DIR_INPUT = 1'b1;
	// Phase counter states
	typedef enum logic [1:0] {ST_IDLE, ST_RUN} run_state_t;
endpackage

// ---- hdl/pwm_prescaler.sv ----
// Prescaler for the period timer: makes a one-cycle tick and two sub-count bits.
// Assumes one system clock; the tick rate is the 4:1 instruction rate divided by the prescale.
`timescale 1ns/1ns
`default_nettype none
module pwm_prescaler
	import pwm_pkg::*;
(
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst,
	// Control
	input  wire logic       run,
	input  wire logic       clear,
	input  wire logic [1:0] prescale,
	// Outputs
	output logic            tick,
	output logic      [1:0] sub_count
);
	typedef struct packed {
		logic [5:0] cnt;
	} pre_state_t;

	pre_state_t s_reg;
	pre_state_t s_next;
	logic [5:0] wrap;

	// Last count value before the timer advances
	always_comb
	begin
		case (prescale)
			PRESCALE_1:  wrap = 6'h03;
			PRESCALE_4:  wrap = 6'h0f;
			default:     wrap = 6'h3f;
		endcase
	end

	// Free count while running, held otherwise so sleep-like stops keep state
	always_comb
	begin
		s_next = s_reg;
		if (clear)
			s_next.cnt = 6'h00;
		else if (run)
			s_next.cnt = (s_reg.cnt == wrap) ? 6'h00 : s_reg.cnt + 6'h01;
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

	assign tick = run && !clear && (s_reg.cnt == wrap);

	// Two fine bits: system clock phase at 1:1, top prescaler bits otherwise
	always_comb
	begin
		case (prescale)
			PRESCALE_1:  sub_count = s_reg.cnt[1:0];
			PRESCALE_4:  sub_count = s_reg.cnt[3:2];
			default:     sub_count = s_reg.cnt[5:4];
		endcase
	end
endmodule
`default_nettype wire

// ---- hdl/pwm_unit.sv ----
// Standard PWM unit with its period timer, duty double buffer and pin routing.
// Assumes a register master on clk_sys with one-cycle strobes and no wait states.
// Operation
// - Compare relies on the system clock; nothing advances while it is stopped.
// - Standard PWM mode drives a waveform on the output pin, up to 10 bits.
// - Period, duty, resolution come only from period, timer, low byte, control registers.
// - All-zero control register releases the pin to the port logic.
// - Control bits 7:6 output config, 5:4 duty LSBs, 3:0 mode select.
// - High is on; zero duty stays low, full duty stays high.
// - Pin functions route to alternate pins under the alternate pin register.
// - After timer equals period: clear timer, set pin unless zero duty, latch duty.
// - Duty is low byte as eight MSBs and control bits 5:4 as two LSBs.
// - Timer plus two sub-count bits form a 10-bit base; match clears the pin.
// - In PWM mode the high byte is read-only and holds the latched duty.
//
// The implementer's own choices: the strobed register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module pwm_unit
	import pwm_pkg::*;
#(
	parameter int NUM_TIMERS = 3
)
(
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst,
	// Register port
	input  wire logic [3:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_write,
	input  wire logic       reg_read,
	output logic      [7:0] reg_rdata,
	// Port logic for the pins when the unit does not own them
	input  wire logic       port_data,
	// Output pins, default and alternate location
	output logic            pin_main_out,
	output logic            pin_main_oe,
	output logic            pin_alt_out,
	output logic            pin_alt_oe
);
	typedef struct packed {
		logic [7:0] unit_control;
		logic [7:0] cc_low;
		logic [7:0] cc_high;
		logic [1:0] duty_latch;
		logic [7:0] period_reg;
		logic [2:0] timer_control;
		logic [7:0] timer_count;
		logic       timer_flag;
		logic [1:0] timer_source;
		logic       alt_pin;
		logic       pin_dir;
		logic       pwm_level;
		logic [7:0] rdata;
	} unit_state_t;

	unit_state_t s_reg;
	unit_state_t s_next;

	logic       tick;
	logic [1:0] sub_count;
	logic       pwm_mode;
	logic       released;
	logic       period_end;
	logic       timer_clear;
	logic       wr_ctl;
	logic [9:0] base;
	logic [9:0] duty_active;
	logic [9:0] duty_pending;
	logic       duty_match;
	logic       pin_value;
	logic       pin_enable;

	// Decode of mode and write strobes
	// field layout
	assign pwm_mode    = (s_reg.unit_control[MODE_MSB:MODE_MSB-1] == MODE_PWM_TOP);
	assign released    = (s_reg.unit_control == RST_ZERO);
	assign wr_ctl      = reg_write && (reg_addr == OFS_TIMER_CONTROL);
	assign timer_clear = reg_write && (reg_addr == OFS_TIMER_COUNT);
	// period end on the tick after equality
	assign period_end  = tick && (s_reg.timer_count == s_reg.period_reg);

	assign base        = {s_reg.timer_count, sub_count};
	assign duty_active = {s_reg.cc_high, s_reg.duty_latch};
	// pending duty: low byte on top, control bits 5:4 below
	assign duty_pending = {s_reg.cc_low, s_reg.unit_control[DUTY_MSB:DUTY_LSB]};
	// match is used directly, so the pin drops in the very cycle the base reaches
	// the duty; waiting for the level flop alone would stretch every pulse by one clock
	assign duty_match   = s_reg.timer_control[RUN_BIT] && (base == duty_active);

	// the prescaler only moves on clk_sys, so a stopped clock freezes all state
	pwm_prescaler pwm_prescaler_i (
		.clk_sys   (clk_sys),
		.rst       (rst),
		.run       (s_reg.timer_control[RUN_BIT]),
		.clear     (timer_clear),
		.prescale  (s_reg.timer_control[PRE_MSB:PRE_LSB]),
		.tick      (tick),
		.sub_count (sub_count)
	);

	// Next-state logic for registers, timer and waveform
	always_comb
	begin
		s_next = s_reg;
		// Register writes
		if (reg_write)
		begin
			case (reg_addr)
				OFS_UNIT_CONTROL:  s_next.unit_control = reg_wdata;
				OFS_CC_LOW_BYTE:   s_next.cc_low = reg_wdata;
				// high byte writable only outside PWM mode
				OFS_CC_HIGH_BYTE:  if (!pwm_mode) s_next.cc_high = reg_wdata;
				OFS_PERIOD_REG:    s_next.period_reg = reg_wdata;
				OFS_TIMER_CONTROL: s_next.timer_control = reg_wdata[2:0];
				OFS_TIMER_COUNT:   s_next.timer_count = RST_ZERO;
				OFS_TIMER_STATUS:  if (reg_wdata[0]) s_next.timer_flag = 1'b0;
				OFS_TIMER_SELECT:  s_next.timer_source = reg_wdata[1:0];
				OFS_ALT_PIN:       s_next.alt_pin = reg_wdata[0];
				OFS_PIN_DIRECTION: s_next.pin_dir = reg_wdata[0];
				default:           s_next.rdata = s_reg.rdata;
			endcase
		end
		// Period timer advance
		// clear timer, set flag, latch duty at period end
		if (tick && !timer_clear)
		begin
			if (period_end)
			begin
				s_next.timer_count = RST_ZERO;
				s_next.timer_flag  = 1'b1;
				if (pwm_mode)
				begin
					s_next.cc_high    = s_reg.cc_low;
					s_next.duty_latch = s_reg.unit_control[DUTY_MSB:DUTY_LSB];
				end
			end
			else
				s_next.timer_count = s_reg.timer_count + 8'h01;
		end
		// Waveform: set at period start unless zero duty, clear on match
		// zero duty never sets; a duty past the period never clears
		// only period, timer, low byte and control shape the wave
		if (!pwm_mode)
			s_next.pwm_level = 1'b0;
		else if (period_end)
			s_next.pwm_level = (duty_pending != 10'h000);
		// match of base and latched duty clears the pin
		else if (duty_match)
			s_next.pwm_level = 1'b0;
		// Read data, one cycle later
		if (reg_read)
		begin
			case (reg_addr)
				OFS_UNIT_CONTROL:  s_next.rdata = s_reg.unit_control;
				OFS_CC_LOW_BYTE:   s_next.rdata = s_reg.cc_low;
				OFS_CC_HIGH_BYTE:  s_next.rdata = s_reg.cc_high;
				OFS_PERIOD_REG:    s_next.rdata = s_reg.period_reg;
				OFS_TIMER_CONTROL: s_next.rdata = {5'h00, s_reg.timer_control};
				OFS_TIMER_COUNT:   s_next.rdata = s_reg.timer_count;
				OFS_TIMER_STATUS:  s_next.rdata = {7'h00, s_reg.timer_flag};
				OFS_TIMER_SELECT:  s_next.rdata = {6'h00, s_reg.timer_source};
				OFS_ALT_PIN:       s_next.rdata = {7'h00, s_reg.alt_pin};
				OFS_PIN_DIRECTION: s_next.rdata = {7'h00, s_reg.pin_dir};
				default:           s_next.rdata = RST_ZERO;
			endcase
		end
		// Flag set wins over a same-cycle clear
		if (period_end)
			s_next.timer_flag = 1'b1;
	end

	// asynchronous reset to constants, single clock
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			s_reg               <= '0;
			s_reg.period_reg    <= RST_PERIOD;
			s_reg.pin_dir       <= RST_DIR_INPUT;
		end
		else
			s_reg <= s_next;
	end

	// Pin ownership: the unit drives whenever direction is output, released or not
	// zero control hands the pin back to port data
	// PWM level goes to the pin in PWM mode
	assign pin_value  = released ? port_data : (pwm_mode ? (s_reg.pwm_level && !duty_match) : port_data);
	assign pin_enable = !s_reg.pin_dir;

	// default location after reset, alternate when selected
	assign pin_main_out = s_reg.alt_pin ? port_data : pin_value;
	assign pin_main_oe  = s_reg.alt_pin ? 1'b0 : pin_enable;
	assign pin_alt_out  = s_reg.alt_pin ? pin_value : 1'b0;
	assign pin_alt_oe   = s_reg.alt_pin ? pin_enable : 1'b0;
	assign reg_rdata    = s_reg.rdata;

	// Checks on the waveform, buffering, timer clear, flag and pin routing
	// zero duty stays low
	AST_ZERO_DUTY_LOW: assert property (@(posedge clk_sys) disable iff (rst)
		(pwm_mode && period_end && {s_reg.cc_low, s_reg.unit_control[5:4]} == 10'h000) |=> !s_reg.pwm_level)
		else $error("Zero duty set the output");
	AST_LATCH_DUTY: assert property (@(posedge clk_sys) disable iff (rst)
		(pwm_mode && period_end) |=> (s_reg.cc_high == $past(s_reg.cc_low)))
		else $error("Duty not latched at period end");
	AST_TIMER_CLEAR: assert property (@(posedge clk_sys) disable iff (rst)
		(period_end && !timer_clear) |=> (s_reg.timer_count == 8'h00))
		else $error("Timer not cleared at period end");
	AST_HIGH_RO: assert property (@(posedge clk_sys) disable iff (rst)
		(pwm_mode && !period_end) |=> $stable(s_reg.cc_high))
		else $error("High byte changed outside period end");
	AST_RELEASE: assert property (@(posedge clk_sys) disable iff (rst)
		(released && !s_reg.alt_pin) |-> (pin_main_out == port_data))
		else $error("Pin not released");
	AST_MATCH_CLEAR: assert property (@(posedge clk_sys) disable iff (rst)
		(pwm_mode && !period_end && s_reg.timer_control[2] && base == duty_active) |=> !s_reg.pwm_level)
		else $error("Match did not clear output");
	AST_ALT_ROUTE: assert property (@(posedge clk_sys) disable iff (rst)
		s_reg.alt_pin |-> (!pin_main_oe && pin_alt_oe == !s_reg.pin_dir))
		else $error("Alternate routing wrong");
	AST_FLAG_SET: assert property (@(posedge clk_sys) disable iff (rst)
		period_end |=> s_reg.timer_flag)
		else $error("Timer flag not set");
	AST_NON_PWM_LOW: assert property (@(posedge clk_sys) disable iff (rst)
		!pwm_mode |=> !s_reg.pwm_level)
		else $error("Level high outside PWM");

	// Checks on the pin level, the time base, the duty pairing, the register port and the alternate pin
	// pin low on match
	AST_PIN_MATCH_LOW: assert property (@(posedge clk_sys) disable iff (rst)
		(pwm_mode && duty_match && !s_reg.alt_pin) |-> !pin_main_out)
		else $error("Output high while base equals duty");

	AST_PERIOD_SET: assert property (@(posedge clk_sys) disable iff (rst)
		(pwm_mode && period_end && duty_pending != 10'h000) |=> s_reg.pwm_level)
		else $error("Output not set at period end");

	AST_LSB_LATCH: assert property (@(posedge clk_sys) disable iff (rst)
		(pwm_mode && period_end) |=> (s_reg.duty_latch == $past(s_reg.unit_control[DUTY_MSB:DUTY_LSB])))
		else $error("Duty low bits not latched");

	AST_FULL_DUTY_HIGH: assert property (@(posedge clk_sys) disable iff (rst)
		(pwm_mode && !period_end && s_reg.pwm_level && s_reg.timer_count <= s_reg.period_reg
			&& duty_active > {s_reg.period_reg, 2'b11}) |=> s_reg.pwm_level)
		else $error("Over-range duty dropped the output");

	AST_TIMER_STEP: assert property (@(posedge clk_sys) disable iff (rst)
		(tick && !period_end && !timer_clear) |=> (s_reg.timer_count == $past(s_reg.timer_count) + 8'h01))
		else $error("Timer did not advance by one");

	AST_TIMER_HOLD: assert property (@(posedge clk_sys) disable iff (rst)
		(!tick && !timer_clear) |=> $stable(s_reg.timer_count))
		else $error("Timer moved without a tick");

	AST_CTRL_WRITE: assert property (@(posedge clk_sys) disable iff (rst)
		(reg_write && reg_addr == OFS_UNIT_CONTROL) |=> (s_reg.unit_control == $past(reg_wdata)))
		else $error("Control register write lost");

	AST_TIMER_CTRL: assert property (@(posedge clk_sys) disable iff (rst)
		wr_ctl |=> (s_reg.timer_control == $past(reg_wdata[2:0])))
		else $error("Timer control write lost");

	AST_FLAG_CLEAR: assert property (@(posedge clk_sys) disable iff (rst)
		(reg_write && reg_addr == OFS_TIMER_STATUS && reg_wdata[0] && !period_end) |=> !s_reg.timer_flag)
		else $error("Timer flag not cleared");

	AST_HIGH_WRITE_IGNORED: assert property (@(posedge clk_sys) disable iff (rst)
		(pwm_mode && reg_write && reg_addr == OFS_CC_HIGH_BYTE && !period_end) |=> $stable(s_reg.cc_high))
		else $error("High byte took a write in PWM mode");

	AST_UNMAPPED_READ: assert property (@(posedge clk_sys) disable iff (rst)
		(reg_read && reg_addr > OFS_PIN_DIRECTION) |=> (reg_rdata == 8'h00))
		else $error("Unmapped read returned data");

	AST_ALT_IDLE: assert property (@(posedge clk_sys) disable iff (rst)
		!s_reg.alt_pin |-> (!pin_alt_oe && !pin_alt_out && pin_main_oe == !s_reg.pin_dir))
		else $error("Alternate pin active at default location");
endmodule
`default_nettype wire

// ---- verif/pwm_load.sv ----
// External load on the PWM pin: counts high cycles and rising edges.
// Assumes one system clock; a released pin is pulled low by the load.
`timescale 1ns/1ns
`default_nettype none
module pwm_load
(
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst,
	// Pin as driven by the unit
	input  wire logic        pin_out,
	input  wire logic        pin_oe,
	// Running measurements
	output logic      [31:0] high_count,
	output logic      [31:0] rise_count
);
	logic level;
	logic level_reg;
	// Pull-down keeps an undriven pin from showing its last value
	assign level = pin_oe ? pin_out : 1'b0;
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			level_reg  <= 1'b0;
			high_count <= 32'h0;
			rise_count <= 32'h0;
		end
		else
		begin
			level_reg  <= level;
			high_count <= high_count + {31'h0, level};
			rise_count <= rise_count + {31'h0, level & ~level_reg};
		end
	end
endmodule
`default_nettype wire

// ---- verif/test_pwm_unit.sv ----
// Self-checking bench for the PWM unit: register port, waveform, routing.
// Assumes the load model and the unit package are compiled first.
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
	$display("wrong value at %0t: %h vs %h", $time, (g), (e)); end end
module test_pwm_unit;
	import pwm_pkg::*;
	logic        clk_sys = 1'b0;
	logic        rst = 1'b1;
	logic [3:0]  reg_addr = 4'h0;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_write = 1'b0;
	logic        reg_read = 1'b0;
	logic        port_data = 1'b0;
	logic        use_alt = 1'b0;
	logic [7:0]  reg_rdata;
	logic        pin_main_out, pin_main_oe, pin_alt_out, pin_alt_oe;
	logic [31:0] high_count, rise_count;
	int          mismatches = 0;
	int          samples_checked = 0;
	pwm_unit pwm_unit_i (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .port_data(port_data),
		.pin_main_out(pin_main_out), .pin_main_oe(pin_main_oe), .pin_alt_out(pin_alt_out), .pin_alt_oe(pin_alt_oe));
	pwm_load pwm_load_i (.clk_sys(clk_sys), .rst(rst), .pin_out(use_alt ? pin_alt_out : pin_main_out),
		.pin_oe(use_alt ? pin_alt_oe : pin_main_oe), .high_count(high_count), .rise_count(rise_count));
	// Clock and hang guard
	initial forever #25 clk_sys = ~clk_sys;
	initial
	begin
		repeat (100000) @(posedge clk_sys);
		mismatches++;
		tally_and_finish();
	end
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Bus cycles: one-cycle strobes launched just after an edge
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clk_sys);
		reg_write <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk_sys);
		reg_read <= 1'b0;
		#1 d = reg_rdata;
	endtask
	function automatic logic [31:0] scale(input logic [1:0] pre);
		return (pre == PRESCALE_1) ? 32'd1 : (pre == PRESCALE_4) ? 32'd4 : 32'd16;
	endfunction
	// Pulse width saturates at the full period, so over-range duty stays high
	function automatic logic [31:0] exp_high(input logic [9:0] duty, input logic [7:0] per, input logic [1:0] pre);
		logic [31:0] cap;
		cap = {22'h0, duty};
		if (cap > 4 * ({24'h0, per} + 1))
			cap = 4 * ({24'h0, per} + 1);
		return cap * scale(pre);
	endfunction
	task automatic run_case(input logic [1:0] pre, input logic [7:0] per, input logic [9:0] duty, input logic alt);
		logic [31:0] plen, h0, r0;
		logic [7:0]  d;
		int          n;
		plen = 4 * ({24'h0, per} + 1) * scale(pre);
		wr(OFS_PIN_DIRECTION, 8'h01);
		wr(OFS_ALT_PIN, {7'h0, alt});
		use_alt = alt;
		`CHK(pin_main_oe | pin_alt_oe, 1'b0)
		wr(OFS_TIMER_SELECT, 8'($urandom_range(0, 2)));
		wr(OFS_PERIOD_REG, per);
		wr(OFS_UNIT_CONTROL, {2'b00, duty[1:0], MODE_PWM_TOP, 2'b00});
		wr(OFS_CC_LOW_BYTE, duty[9:2]);
		wr(OFS_TIMER_STATUS, 8'h01);
		wr(OFS_TIMER_COUNT, 8'h00);
		wr(OFS_TIMER_CONTROL, {6'h0, pre});
		wr(OFS_TIMER_CONTROL, {5'h0, 1'b1, pre});
		// wait for the flag, then clear the direction bit
		n = 0;
		do
		begin
			rd(OFS_TIMER_STATUS, d);
			n++;
		end
		while (d[0] !== 1'b1 && n < 2000);
		if (n >= 2000)
		begin
			mismatches++;
			tally_and_finish();
		end
		wr(OFS_PIN_DIRECTION, 8'h00);
		// settle two periods so a cut first pulse never enters the count
		repeat (2 * plen) @(posedge clk_sys);
		h0 = high_count;
		r0 = rise_count;
		repeat (2 * plen) @(posedge clk_sys);
		`CHK(high_count - h0, 2 * exp_high(duty, per, pre))
		`CHK(rise_count - r0, (duty == 0 || {22'h0, duty} >= plen / scale(pre)) ? 32'd0 : 32'd2)
		if (alt)
			`CHK(pin_alt_oe, 1'b1)
		rd(OFS_CC_HIGH_BYTE, d);
		`CHK(d, duty[9:2])
		wr(OFS_CC_HIGH_BYTE, ~duty[9:2]);
		rd(OFS_CC_HIGH_BYTE, d);
		`CHK(d, duty[9:2])
		// zero control hands the pin back
		@(posedge clk_sys);
		port_data <= 1'($urandom);
		wr(OFS_UNIT_CONTROL, 8'h00);
		@(posedge clk_sys);
		#1;
		if (!alt)
			`CHK(pin_main_out, port_data)
	endtask
	// Main sequence: reset values, then random and corner cases
	initial
	begin
		logic [7:0] d;
		logic [9:0] duty;
		logic [7:0] per;
		void'($urandom(32'hef5604f4));
		repeat (16) @(posedge clk_sys);
		rst <= 1'b0;
		`CHK(pin_main_oe, 1'b0)
		rd(OFS_UNIT_CONTROL, d);
		`CHK(d, RST_ZERO)
		rd(OFS_CC_LOW_BYTE, d);
		`CHK(d, RST_ZERO)
		rd(OFS_PERIOD_REG, d);
		`CHK(d, RST_PERIOD)
		rd(OFS_PIN_DIRECTION, d);
		`CHK(d[0], RST_DIR_INPUT)
		rd(4'hf, d);
		`CHK(d, 8'h00)
		for (int i = 0; i < 9; i++)
		begin
			per  = 8'($urandom_range(1, 7));
			duty = (i == 0) ? 10'h000 : (i == 1) ? 10'h3ff : 10'($urandom_range(1, 4 * per + 3));
			run_case(2'(i % 3), per, duty, i == 4);
		end
		tally_and_finish();
	end
endmodule
`default_nettype wire
